/* rfhp_pkg.sv */
// Shared constants for the radio host port
package rfhp_pkg;
  localparam logic [7:0] RFHP_ADDR_IRQ_MASK = 8'hE5;
  localparam logic [7:0] RFHP_ADDR_FIFO_STATUS = 8'hE6;
  localparam logic [7:0] RFHP_ADDR_PORT_DATA = 8'hE7;
  localparam logic [7:0] RFHP_ADDR_LINK_CONTROL = 8'hE8;
  localparam logic [3:0] RFHP_IRQ_MASK_RESET = 4'hF;
  localparam logic [3:0] RFHP_FIFO_STATUS_RESET = 4'h3;
  localparam logic [7:0] RFHP_PORT_DATA_RESET = 8'h00;
  localparam logic [1:0] RFHP_LINK_CONTROL_RESET = 2'h2;
  localparam int RFHP_BIT_RX_FULL = 3;
  localparam int RFHP_BIT_RX_AVAIL = 2;
  localparam int RFHP_BIT_TX_EMPTY = 1;
  localparam int RFHP_BIT_TX_SLOT = 0;
  localparam int RFHP_BIT_CSN = 1;
  localparam int RFHP_BIT_CE = 0;
  localparam int RFHP_BYTE_BITS = 8;
  localparam int RFHP_FIFO_DEPTH = 2;
  localparam logic [1:0] RFHP_LAST_PHASE = 2'h3;
  localparam logic [2:0] RFHP_LAST_BIT = 3'h7;
endpackage

/* rfhp_fifo.sv */
// Two-entry byte FIFO used for both directions of the host port
`timescale 1ns/10ps
module rfhp_fifo
  import rfhp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_push,
  input wire logic [7:0] i_wdata,
  input wire logic i_pop,
  output logic [7:0] o_rdata,
  output logic o_full,
  output logic o_empty
);
  typedef struct packed {
    logic [RFHP_FIFO_DEPTH-1:0][7:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } rfhp_fifo_type;

  rfhp_fifo_type q, d;
  logic do_push;
  logic do_pop;

  assign o_full = (q.cnt == 2'h2);
  assign o_empty = (q.cnt == 2'h0);
  assign o_rdata = q.mem[q.rp];

  always_comb begin
    d = q;
    // Push to a full FIFO and pop from an empty one are dropped
    do_push = i_push && !o_full;
    do_pop = i_pop && !o_empty;
    if (do_push) begin
      d.mem[q.wp] = i_wdata;
      d.wp = ~q.wp;
    end
    if (do_pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_en) begin
      q <= d;
    end
  end

  a_fifo_count: assert property (@(posedge i_clk) disable iff (i_rst)
    i_en && i_push && !o_full && !i_pop |=> !o_empty)
    else $error("fifo push did not leave data");
endmodule // rfhp_fifo

/* rfhp_shifter.sv */
// Link-clock serial shifter: one byte per request toggle, MSB first
`timescale 1ns/10ps
module rfhp_shifter
  import rfhp_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic i_req_tgl,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_miso,
  output logic o_ack_tgl,
  output logic [7:0] o_rx_byte,
  output logic o_sck,
  output logic o_mosi
);
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic miso_s1;
    logic miso_s2;
    logic busy;
    logic [1:0] phase;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ack;
    logic sck;
    logic mosi;
  } rfhp_shift_type;

  rfhp_shift_type q, d;
  logic start;

  assign o_ack_tgl = q.ack;
  assign o_rx_byte = q.rx;
  assign o_sck = q.sck;
  assign o_mosi = q.mosi;
  assign start = !q.busy && (q.req_s2 != q.ack);

  always_comb begin
    d = q;
    d.req_s1 = i_req_tgl;
    d.req_s2 = q.req_s1;
    d.miso_s1 = i_miso;
    d.miso_s2 = q.miso_s1;
    d.sck = 1'b0;
    if (start) begin
      // Core holds the byte steady until the ack toggle returns
      d.busy = 1'b1;
      d.phase = 2'h0;
      d.cnt = 3'h0;
      d.sh = i_tx_byte;
      d.mosi = i_tx_byte[7];
    end else if (q.busy) begin
      d.phase = q.phase + 2'h1;
      // Four link cycles per bit leave room for the input synchroniser
      d.sck = (q.phase == 2'h0) || (q.phase == 2'h1);
      if (q.phase == RFHP_LAST_PHASE) begin
        d.sh = {q.sh[6:0], q.miso_s2};
        d.mosi = q.sh[6];
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == RFHP_LAST_BIT) begin
          d.busy = 1'b0;
          d.rx = {q.sh[6:0], q.miso_s2};
          d.ack = ~q.ack;
        end
      end
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_shift_msb: assert property (@(posedge i_link_clk) disable iff (i_rst)
    start |=> o_mosi == $past(i_tx_byte[7]))
    else $error("first bit out is not the msb");
  a_shift_len: assert property (@(posedge i_link_clk) disable iff (i_rst)
    start |-> ##33 (o_ack_tgl != $past(o_ack_tgl)))
    else $error("byte did not finish in 32 link cycles");
endmodule // rfhp_shifter

/* rfhp_host_port.sv */
// Host port to the radio: register file, FIFOs, handshake to the link shifter
//
// Behaviour
// - Config bit 3 set masks the receive-FIFO-full interrupt.
// - Config bit 2 set masks the receive-data-available interrupt.
// - Config bit 1 set masks the transmit-FIFO-empty interrupt.
// - Config bit 0 set masks transmit-slot-free interrupt; mask resets to 0x0F.
// - Status bit 3 shows receive FIFO full; resets to 0.
// - Status bit 2 shows a received byte waiting; resets to 0.
// - Status bit 1 transmit empty, bit 0 transmit slot free; both reset 1.
// - Data register writes push transmit FIFO, reads pop receive FIFO, two deep.
// - Each finished serial byte raises byte-done interrupt unless masked; code pulses it only while an unmasked status source is active.
// - Control bit 1 drives active-low chip select, resets to 1.
// - Control bit 0 drives chip enable, resets to 0.
// - Radio raises retry-limit event when retry counter exceeds retry limit.
// - After retry-limit the payload stays; chip-enable toggle resends it.
// - Receiver's data-sent for ack payload comes after the next new packet.
// - Transmitter receiving ack with payload raises data-sent and data-received.
// - Receiver drops repeated packet with same identifier, no new data-received.
// - First byte returned for a command is the radio status.
// - Command and data bytes shift most significant bit first.
`timescale 1ns/10ps
module rfhp_host_port
  import rfhp_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  output logic O_PORT_IRQ,
  output logic O_BYTE_DONE_IRQ,
  input wire logic I_LINK_CLK,
  output logic O_RF_SCK,
  output logic O_RF_MOSI,
  input wire logic I_RF_MISO,
  output logic O_RF_CSN,
  output logic O_RF_CE,
  input wire logic I_RADIO_IRQ,
  output logic O_RADIO_IRQ
);
  typedef struct packed {
    logic [3:0] mask;
    logic [1:0] ctrl;
    logic [7:0] rdata;
    logic [7:0] tx_hold;
    logic req;
    logic in_flight;
    logic ack_s1;
    logic ack_s2;
    logic irq_s1;
    logic irq_s2;
    logic done;
  } rfhp_core_type;

  rfhp_core_type q, d;

  logic [7:0] tx_head;
  logic tx_full;
  logic tx_empty;
  logic [7:0] rx_head;
  logic rx_full;
  logic rx_empty;
  logic [7:0] link_rx_byte;
  logic link_ack;
  logic wr_data;
  logic rd_data;
  logic start_byte;
  logic byte_done;
  logic [3:0] status;
  logic [3:0] irq_src;

  assign wr_data = I_SFR_WR && (I_SFR_ADDR == RFHP_ADDR_PORT_DATA);
  assign rd_data = I_SFR_RD && (I_SFR_ADDR == RFHP_ADDR_PORT_DATA);
  // Waits for room in the receive FIFO so a finished byte is never lost
  assign start_byte = !q.in_flight && !tx_empty && !rx_full;
  assign byte_done = q.in_flight && (q.ack_s2 == q.req);

  assign status[RFHP_BIT_RX_FULL] = rx_full;
  assign status[RFHP_BIT_RX_AVAIL] = !rx_empty;
  assign status[RFHP_BIT_TX_EMPTY] = tx_empty;
  assign status[RFHP_BIT_TX_SLOT] = !tx_full;

  // A set mask bit silences its source
  assign irq_src = status & ~q.mask;

  rfhp_fifo u_tx_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_en(I_CLK_EN),
    .i_push(wr_data),
    .i_wdata(I_SFR_WDATA),
    .i_pop(start_byte),
    .o_rdata(tx_head),
    .o_full(tx_full),
    .o_empty(tx_empty)
  );

  rfhp_fifo u_rx_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_en(I_CLK_EN),
    .i_push(byte_done),
    .i_wdata(link_rx_byte),
    .i_pop(rd_data),
    .o_rdata(rx_head),
    .o_full(rx_full),
    .o_empty(rx_empty)
  );

  rfhp_shifter u_shifter (
    .i_link_clk(I_LINK_CLK),
    .i_rst(I_SYS_RST),
    .i_req_tgl(q.req),
    .i_tx_byte(q.tx_hold),
    .i_miso(I_RF_MISO),
    .o_ack_tgl(link_ack),
    .o_rx_byte(link_rx_byte),
    .o_sck(O_RF_SCK),
    .o_mosi(O_RF_MOSI)
  );

  always_comb begin
    d = q;
    d.ack_s1 = link_ack;
    d.ack_s2 = q.ack_s1;
    // Radio events pass through; sequencing lives in the radio
    d.irq_s1 = I_RADIO_IRQ;
    d.irq_s2 = q.irq_s1;
    d.done = byte_done;
    if (start_byte) begin
      // Request toggle crosses; the byte itself stays parked in tx_hold
      d.tx_hold = tx_head;
      d.req = ~q.req;
      d.in_flight = 1'b1;
    end else if (byte_done) begin
      d.in_flight = 1'b0;
    end
    if (I_SFR_WR) begin
      case (I_SFR_ADDR)
        RFHP_ADDR_IRQ_MASK: begin
          d.mask = I_SFR_WDATA[3:0];
        end
        RFHP_ADDR_LINK_CONTROL: begin
          // Payload is kept by the radio; ce toggle restarts it
          d.ctrl = I_SFR_WDATA[1:0];
        end
        default: begin
          d.mask = q.mask;
        end
      endcase
    end
    if (I_SFR_RD) begin
      case (I_SFR_ADDR)
        RFHP_ADDR_IRQ_MASK: begin
          d.rdata = {4'h0, q.mask};
        end
        RFHP_ADDR_FIFO_STATUS: begin
          d.rdata = {4'h0, status};
        end
        RFHP_ADDR_PORT_DATA: begin
          d.rdata = rx_empty ? 8'h00 : rx_head;
        end
        RFHP_ADDR_LINK_CONTROL: begin
          d.rdata = {6'h00, q.ctrl};
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q <= '0;
      q.mask <= RFHP_IRQ_MASK_RESET;
      q.ctrl <= RFHP_LINK_CONTROL_RESET;
      q.rdata <= RFHP_PORT_DATA_RESET;
    end else if (I_CLK_EN) begin
      q <= d;
    end
  end

  assign O_SFR_RDATA = q.rdata;
  assign O_PORT_IRQ = |irq_src;
  // Pulse only when some unmasked source is active
  assign O_BYTE_DONE_IRQ = q.done && (|irq_src);
  assign O_RF_CSN = q.ctrl[RFHP_BIT_CSN];
  assign O_RF_CE = q.ctrl[RFHP_BIT_CE];
  assign O_RADIO_IRQ = q.irq_s2;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_byte_sent;
    I_CLK_EN && start_byte;
  endsequence
  sequence s_byte_back;
    q.in_flight ##1 (I_CLK_EN && byte_done);
  endsequence
  sequence s_two_enabled;
    I_CLK_EN ##1 I_CLK_EN;
  endsequence
  sequence s_data_read;
    I_CLK_EN && rd_data;
  endsequence

  a_rxfull_mask: assert property (rx_full && !q.mask[3] |-> O_PORT_IRQ)
    else $error("rx full interrupt lost");
  a_rxavail_mask: assert property (q.mask == 4'hB |-> O_PORT_IRQ == (!rx_empty))
    else $error("rx data interrupt wrong");
  a_txempty_mask: assert property (q.mask == 4'hD |-> O_PORT_IRQ == tx_empty)
    else $error("tx empty interrupt wrong");
  a_txslot_mask: assert property (q.mask == 4'hE |-> O_PORT_IRQ == !tx_full)
    else $error("tx slot interrupt wrong");
  a_status_read: assert property (I_CLK_EN && I_SFR_RD
    && I_SFR_ADDR == RFHP_ADDR_FIFO_STATUS |=> O_SFR_RDATA[3:0]
    == {$past(rx_full), !$past(rx_empty), $past(tx_empty), !$past(tx_full)})
    else $error("status read mismatch");
  a_empty_slot: assert property (tx_empty |-> !tx_full)
    else $error("tx empty but no slot");
  a_csn_write: assert property (I_CLK_EN && I_SFR_WR
    && I_SFR_ADDR == RFHP_ADDR_LINK_CONTROL |=> O_RF_CSN == $past(I_SFR_WDATA[1]))
    else $error("chip select not written");
  a_ce_write: assert property (I_CLK_EN && I_SFR_WR
    && I_SFR_ADDR == RFHP_ADDR_LINK_CONTROL |=> O_RF_CE == $past(I_SFR_WDATA[0]))
    else $error("chip enable not written");
  a_byte_start: assert property (s_byte_sent |=> q.in_flight && q.req != $past(q.req))
    else $error("byte start missed");
  a_byte_push: assert property (s_byte_back |=> !rx_empty)
    else $error("received byte not queued");
  a_done_irq: assert property (I_CLK_EN && byte_done && q.mask == 4'h0
    |=> O_BYTE_DONE_IRQ)
    else $error("byte done pulse missing");

  // Radio line is a level only; a pulse shorter than one clock may vanish
  a_radio_sync: assert property (
    s_two_enabled |=> O_RADIO_IRQ == $past(I_RADIO_IRQ, 2))
    else $error("radio event line not forwarded");
  a_rdata_hold: assert property (
    !(I_CLK_EN && I_SFR_RD) |=> $stable(O_SFR_RDATA))
    else $error("read data changed without a read");
  a_data_pop: assert property (
    s_data_read && !rx_empty |=> O_SFR_RDATA == $past(rx_head))
    else $error("data read lost the receive head");
  a_data_empty: assert property (
    s_data_read && rx_empty |=> O_SFR_RDATA == 8'h00)
    else $error("empty data read not zero");
  a_pop_count: assert property (
    s_data_read && rx_full && !byte_done |=> !rx_full)
    else $error("data read did not pop");
  a_tx_refuse: assert property (
    I_CLK_EN && wr_data && tx_full && !start_byte |=> tx_full)
    else $error("write to full transmit queue changed it");
  a_tx_push: assert property (
    I_CLK_EN && wr_data && !tx_full |=> !tx_empty)
    else $error("data write not queued");
  a_mask_write: assert property (I_CLK_EN && I_SFR_WR
    && I_SFR_ADDR == RFHP_ADDR_IRQ_MASK |=> q.mask == $past(I_SFR_WDATA[3:0]))
    else $error("mask not written");
  a_freeze_ctrl: assert property (
    !I_CLK_EN |=> $stable(q.ctrl) && $stable(q.mask))
    else $error("registers moved while frozen");
  a_freeze_fifo: assert property (
    !I_CLK_EN |=> $stable(status))
    else $error("queue flags moved while frozen");
  a_backpressure: assert property (
    I_CLK_EN && rx_full |=> $stable(q.req))
    else $error("byte started into a full receive queue");
  a_flight_end: assert property (
    I_CLK_EN && byte_done |=> !q.in_flight)
    else $error("byte still in flight after return");
  a_hold_steady: assert property (
    q.in_flight && $past(q.in_flight) |-> $stable(q.tx_hold))
    else $error("parked byte changed in flight");
  a_start_pop: assert property (
    s_byte_sent |=> q.tx_hold == $past(tx_head))
    else $error("started byte is not the queue head");
  a_done_push: assert property (
    I_CLK_EN && byte_done && rx_empty |=> rx_head == $past(link_rx_byte))
    else $error("returned byte not at receive head");
  a_tx_order: assert property (
    tx_full |-> !tx_empty)
    else $error("transmit full and empty together");
  a_rx_order: assert property (
    rx_full |-> !rx_empty)
    else $error("receive full and empty together");
  a_done_masked: assert property (
    q.mask == RFHP_IRQ_MASK_RESET |-> !O_BYTE_DONE_IRQ)
    else $error("byte done pulse while all masked");
endmodule // rfhp_host_port

/* rfhp_radio_model.sv */
// Behavioural radio-side serial slave for the host port bench
`timescale 1ns/10ps
module rfhp_radio_model #(
  parameter logic [7:0] STATUS_BYTE = 8'h0E
) (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_csn,
  output logic o_miso,
  output logic [7:0] o_rx_byte,
  output int o_rx_cnt
);
  logic [7:0] sr = STATUS_BYTE;
  logic cap = 1'b0;
  int bc = 0;
  initial o_rx_cnt = 0;
  initial o_rx_byte = 8'h00;
  // Status leads every command after select falls
  always @(negedge i_csn) begin
    sr = STATUS_BYTE;
    bc = 0;
  end
  always @(posedge i_sck) if (!i_csn) cap = i_mosi;
  // Shift on falling edge, MSB first; echoes the byte it took
  always @(negedge i_sck) if (!i_csn) begin
    sr = {sr[6:0], cap};
    bc++;
    if (bc == 8) begin
      o_rx_byte = sr;
      o_rx_cnt++;
      bc = 0;
    end
  end
  // Deselected line shows the inverted low bit of the shift register
  assign o_miso = i_csn ? ~sr[0] : sr[7];
endmodule // rfhp_radio_model

/* rfhp_host_port_tb_top.sv */
// Self-checking bench for the radio host port
`timescale 1ns/10ps
module rfhp_host_port_tb_top;
  import rfhp_pkg::*;
  localparam logic [7:0] STAT_B = 8'h0E;
  logic I_CLK = 1'b0;
  logic I_LINK_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_CLK_EN = 1'b1;
  logic [7:0] I_SFR_ADDR = 8'h00;
  logic I_SFR_WR = 1'b0;
  logic I_SFR_RD = 1'b0;
  logic [7:0] I_SFR_WDATA = 8'h00;
  logic I_RADIO_IRQ = 1'b0;
  logic [7:0] O_SFR_RDATA;
  logic O_PORT_IRQ, O_BYTE_DONE_IRQ, O_RF_SCK, O_RF_MOSI, I_RF_MISO, O_RF_CSN, O_RF_CE;
  logic O_RADIO_IRQ;
  logic [7:0] rx_byte;
  logic [7:0] exp_q[$];
  logic [7:0] nxt;
  int rx_cnt;
  int err_total = 0;
  int total_checks = 0;
  int done_cnt = 0;
  int cyc = 0;
  always #50 I_CLK = ~I_CLK;
  always #62.5 I_LINK_CLK = ~I_LINK_CLK;
  rfhp_host_port rfhp_host_port_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CLK_EN(I_CLK_EN),
    .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
    .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .O_PORT_IRQ(O_PORT_IRQ),
    .O_BYTE_DONE_IRQ(O_BYTE_DONE_IRQ), .I_LINK_CLK(I_LINK_CLK), .O_RF_SCK(O_RF_SCK),
    .O_RF_MOSI(O_RF_MOSI), .I_RF_MISO(I_RF_MISO), .O_RF_CSN(O_RF_CSN), .O_RF_CE(O_RF_CE),
    .I_RADIO_IRQ(I_RADIO_IRQ), .O_RADIO_IRQ(O_RADIO_IRQ));
  rfhp_radio_model #(.STATUS_BYTE(STAT_B)) rfhp_radio_model_i (.i_sck(O_RF_SCK),
    .i_mosi(O_RF_MOSI), .i_csn(O_RF_CSN), .o_miso(I_RF_MISO), .o_rx_byte(rx_byte),
    .o_rx_cnt(rx_cnt));
  always @(posedge I_CLK) if (O_BYTE_DONE_IRQ === 1'b1) done_cnt++;
  task automatic final_report;
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, several times the expected run
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    #1;
    I_SFR_ADDR = a;
    I_SFR_WDATA = d;
    I_SFR_WR = 1'b1;
    @(posedge I_CLK);
    #1;
    I_SFR_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge I_CLK);
    #1;
    I_SFR_ADDR = a;
    I_SFR_RD = 1'b1;
    @(posedge I_CLK);
    #1;
    I_SFR_RD = 1'b0;
    d = O_SFR_RDATA;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] s;
    rd(a, s);
    chk(nm, e, s);
  endtask
  // Model echoes the previous byte, so each send queues what comes back
  task automatic send(input logic [7:0] d);
    wr(RFHP_ADDR_PORT_DATA, d);
    exp_q.push_back(nxt);
    nxt = d;
  endtask
  task automatic pop_chk;
    rchk("rx data", RFHP_ADDR_PORT_DATA, exp_q.pop_front());
  endtask
  task automatic wait_stat(input logic [3:0] e);
    logic [7:0] s;
    for (int k = 0; k < 150; k++) begin
      rd(RFHP_ADDR_FIFO_STATUS, s);
      if (s[3:0] === e) break;
    end
    chk("status", {4'h0, e}, s);
  endtask
  function automatic logic irq_exp(input logic [3:0] st, input logic [3:0] m);
    return |(st & ~m);
  endfunction
  task automatic sweep(input logic [3:0] st);
    for (int m = 0; m < 16; m++) begin
      wr(RFHP_ADDR_IRQ_MASK, 8'(m));
      chk("irq", {7'h00, irq_exp(st, 4'(m))}, {7'h00, O_PORT_IRQ});
      rchk("mask", RFHP_ADDR_IRQ_MASK, 8'(m));
    end
    wr(RFHP_ADDR_IRQ_MASK, 8'h0B);
  endtask
  initial begin
    void'($urandom(32'h106B7BE2));
    repeat (2) @(posedge I_CLK);
    #1;
    I_SYS_RST = 1'b0;
    rchk("mask rst", RFHP_ADDR_IRQ_MASK, 8'h0F);
    rchk("stat rst", RFHP_ADDR_FIFO_STATUS, 8'h03);
    rchk("data rst", RFHP_ADDR_PORT_DATA, 8'h00);
    rchk("ctl rst", RFHP_ADDR_LINK_CONTROL, 8'h02);
    chk("csn rst", 8'h01, {7'h00, O_RF_CSN});
    chk("ce rst", 8'h00, {7'h00, O_RF_CE});
    for (int i = 0; i < 4; i++) begin
      wr(RFHP_ADDR_LINK_CONTROL, 8'(i));
      chk("pins", 8'(i), {6'h00, O_RF_CSN, O_RF_CE});
      rchk("ctl", RFHP_ADDR_LINK_CONTROL, 8'(i));
    end
    wr(8'hE9, 8'($urandom));
    rchk("unmapped", 8'hE9, 8'h00);
    // Select falls before the command byte
    wr(RFHP_ADDR_LINK_CONTROL, 8'h00);
    nxt = STAT_B;
    send(8'($urandom));
    wait_stat(4'h7);
    chk("done masked", 8'h00, 8'(done_cnt));
    sweep(4'h7);
    pop_chk;
    done_cnt = 0;
    // Fill tx, refused write, rx back-pressure
    for (int i = 0; i < 3; i++) send(8'($urandom));
    rchk("tx full", RFHP_ADDR_FIFO_STATUS, 8'h00);
    wr(RFHP_ADDR_PORT_DATA, 8'($urandom));
    wait_stat(4'hD);
    sweep(4'hD);
    pop_chk;
    wait_stat(4'hF);
    pop_chk;
    pop_chk;
    wait_stat(4'h3);
    rchk("rx empty", RFHP_ADDR_PORT_DATA, 8'h00);
    chk("done", 8'h03, 8'(done_cnt));
    chk("link bytes", 8'h04, 8'(rx_cnt));
    chk("msb first", nxt, rx_byte);
    I_RADIO_IRQ = 1'b1;
    repeat (3) @(posedge I_CLK);
    #1;
    chk("radio irq", 8'h01, {7'h00, O_RADIO_IRQ});
    I_RADIO_IRQ = 1'b0;
    repeat (3) @(posedge I_CLK);
    #1;
    chk("radio irq", 8'h00, {7'h00, O_RADIO_IRQ});
    // Frozen core ignores a register write
    I_CLK_EN = 1'b0;
    I_SFR_ADDR = RFHP_ADDR_LINK_CONTROL;
    I_SFR_WDATA = 8'h01;
    I_SFR_WR = 1'b1;
    @(posedge I_CLK);
    #1;
    I_SFR_WR = 1'b0;
    I_CLK_EN = 1'b1;
    chk("frozen pins", 8'h00, {6'h00, O_RF_CSN, O_RF_CE});
    // New command after the turnaround gap, unmasked byte-done
    wr(RFHP_ADDR_LINK_CONTROL, 8'h02);
    repeat (2100) @(posedge I_CLK);
    wr(RFHP_ADDR_IRQ_MASK, 8'h00);
    wr(RFHP_ADDR_LINK_CONTROL, 8'h00);
    done_cnt = 0;
    nxt = STAT_B;
    send(8'hE1);
    wait_stat(4'h7);
    chk("done unmasked", 8'h01, 8'(done_cnt));
    pop_chk;
    // Reset again in mid-run
    I_SYS_RST = 1'b1;
    repeat (2) @(posedge I_CLK);
    #1;
    I_SYS_RST = 1'b0;
    rchk("mask rst2", RFHP_ADDR_IRQ_MASK, 8'h0F);
    rchk("stat rst2", RFHP_ADDR_FIFO_STATUS, 8'h03);
    rchk("ctl rst2", RFHP_ADDR_LINK_CONTROL, 8'h02);
    final_report;
  end
endmodule // rfhp_host_port_tb_top
